// ==== core/ov_pkg.sv ====
// Function
// - fault threshold is unsigned, scaled two to minus thirteen
// - fault threshold resets to 1.10 times strap
// - fault exceedance sets summary and fault bits, alerts
// - response byte defaults 80h, only mode 10
// - retry field zero latches output off
// - nonzero retry field restarts until off or shutdown
// - restart waits for output below warning threshold
// - retry delay is (field plus one) times 35ms
// - warning exceedance sets summary and warning bits, alerts
// - warning threshold resets 1.08 times strap, range-checked
// - warning still set when a fast rise crosses both
`default_nettype none

package ov_pkg;
  localparam logic [7:0] CMD_OV_FAULT_THR = 8'h40;
  localparam logic [7:0] CMD_OV_RESPONSE = 8'h41;
  localparam logic [7:0] CMD_OV_WARN_THR = 8'h42;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7A;

  localparam logic [7:0] RESP_RESET = 8'h80;
  localparam int RESP_MODE_MSB = 7;
  localparam int RESP_MODE_LSB = 6;
  localparam int RESP_RETRY_MSB = 5;
  localparam int RESP_RETRY_LSB = 3;
  localparam int RESP_DELAY_MSB = 2;
  localparam int RESP_DELAY_LSB = 0;
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;

  // linear-16 unsigned: volts = value * 2^-13
  localparam int LIN16_FRAC_BITS = 13;
  localparam int THR_MAX_VOLTS = 6;
  localparam logic [15:0] FAULT_THR_MAX =
    16'(THR_MAX_VOLTS << LIN16_FRAC_BITS);
  localparam logic [15:0] WARN_THR_MAX = FAULT_THR_MAX;

  // strap multipliers in Q10: 1.10 and 1.08
  localparam int SCALE_FRAC_BITS = 10;
  localparam logic [10:0] FAULT_SCALE = 11'h466;
  localparam logic [10:0] WARN_SCALE = 11'h452;

  localparam int SV_OV_FAULT_BIT = 7;
  localparam int SV_OV_WARN_BIT = 6;
  localparam logic [7:0] SV_ZERO = 8'h00;

  localparam int CLK_PERIOD_NS = 4;
  localparam int RETRY_UNIT_NS = 35000000;
  localparam int RETRY_UNIT_CYCLES_DEF = RETRY_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [15:0] rdata;
  } cmd_rsp_t;
endpackage : ov_pkg

`default_nettype wire

// ==== core/retry_timer.sv ====
`default_nettype none

module retry_timer #(
  parameter int UNIT_CYCLES = ov_pkg::RETRY_UNIT_CYCLES_DEF,
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [2:0] delay_sel,
  output logic done
);
  import ov_pkg::*;

  logic [CNT_W-1:0] unit_cnt_r;
  logic [2:0] units_left_r;
  logic running_r;
  logic done_r;
  logic [31:0] elapsed_r;
  logic [2:0] sel_seen_r;

  // whole delay counted in units, so (sel+1) units end it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unit_cnt_r <= '0;
      units_left_r <= '0;
      running_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      unit_cnt_r <= CNT_W'(UNIT_CYCLES - 1);
      units_left_r <= delay_sel;
      running_r <= 1'b1;
      done_r <= 1'b0;
    end else if (running_r) begin
      if (unit_cnt_r != '0) begin
        unit_cnt_r <= unit_cnt_r - 1'b1;
      end else if (units_left_r != '0) begin
        unit_cnt_r <= CNT_W'(UNIT_CYCLES - 1);
        units_left_r <= units_left_r - 1'b1;
      end else begin
        running_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  assign done = done_r;

  // helper for checking only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      elapsed_r <= '0;
      sel_seen_r <= '0;
    end else if (start) begin
      elapsed_r <= 32'h0;
      sel_seen_r <= delay_sel;
    end else if (running_r) begin
      elapsed_r <= elapsed_r + 32'h1;
    end
  end

  AST_DELAY_LENGTH: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(done_r) |->
      elapsed_r == (32'(sel_seen_r) + 32'h1) * 32'(UNIT_CYCLES))
    else $error("retry delay length wrong");
endmodule : retry_timer

`default_nettype wire

// ==== core/vout_overvoltage_fault_manager.sv ====
`default_nettype none

module vout_overvoltage_fault_manager #(
  parameter int RETRY_UNIT_CYCLES = ov_pkg::RETRY_UNIT_CYCLES_DEF,
  parameter int TIMER_W = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire ov_pkg::cmd_req_t cmd,
  output ov_pkg::cmd_rsp_t rsp,
  input wire logic [15:0] vout_meas,
  input wire logic [15:0] setpoint_address_strap,
  input wire logic write_protect_pin,
  input wire logic output_on_request,
  input wire logic other_fault_shutdown,
  input wire logic host_alert_in,
  output logic host_alert_output,
  output logic host_alert_oe_n,
  output logic alert_line_low,
  output logic power_stage_enable,
  output logic status_word_vout,
  output logic status_vout_ov_fault,
  output logic status_vout_ov_warn
);
  import ov_pkg::*;

  typedef enum logic [2:0] {
    ST_INIT, ST_RUN, ST_OFF, ST_WAIT, ST_LATCH
  } fsm_t;

  fsm_t state_r;
  fsm_t state_nxt;
  logic captured_r;
  logic [15:0] fault_thr_r;
  logic [15:0] warn_thr_r;
  logic [7:0] resp_r;
  logic fault_r;
  logic fault_nxt;
  logic warn_r;
  logic warn_nxt;
  logic wp_meta_r;
  logic wp_sync_r;
  logic alert_meta_r;
  logic power_en_r;
  logic alert_oe_n_r;
  logic alert_low_r;
  logic sum_r;
  cmd_rsp_t rsp_r;
  logic fault_now;
  logic warn_now;
  logic below_warn;
  logic clear_req;
  logic wr_req;
  logic wr_fault_ok;
  logic wr_resp_ok;
  logic wr_warn_ok;
  logic timer_start;
  logic timer_done;
  logic [2:0] retry_field;

  function automatic logic [15:0] scale_strap(input logic [15:0] v,
                                              input logic [10:0] k);
    logic [26:0] prod;
    logic [16:0] shifted;
    prod = 27'(v) * 27'(k);
    shifted = prod[SCALE_FRAC_BITS +: 17];
    scale_strap = shifted[16] ? 16'hFFFF : shifted[15:0];
  endfunction : scale_strap

  // pins from outside the clock domain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_meta_r <= 1'b0;
      wp_sync_r <= 1'b0;
      alert_meta_r <= 1'b1;
      alert_low_r <= 1'b0;
    end else begin
      wp_meta_r <= write_protect_pin;
      wp_sync_r <= wp_meta_r;
      alert_meta_r <= host_alert_in;
      alert_low_r <= ~alert_meta_r;
    end
  end

  // linear-16 counts compare directly as volts * 2^13
  assign fault_now = captured_r && (vout_meas > fault_thr_r);
  // fast rises may cross both in one sample; warn is then set as well
  assign warn_now = captured_r && (vout_meas > warn_thr_r);
  assign below_warn = vout_meas < warn_thr_r;
  assign retry_field = resp_r[RESP_RETRY_MSB:RESP_RETRY_LSB];

  assign wr_req = cmd.valid && cmd.write;
  assign clear_req = wr_req && (cmd.code == CMD_CLEAR_FAULTS);
  assign wr_fault_ok = wr_req && (cmd.code == CMD_OV_FAULT_THR) &&
    !wp_sync_r && (cmd.wdata <= FAULT_THR_MAX);
  assign wr_warn_ok = wr_req && (cmd.code == CMD_OV_WARN_THR) &&
    !wp_sync_r && (cmd.wdata <= WARN_THR_MAX);
  // unused response modes are refused, so mode is always 10
  assign wr_resp_ok = wr_req && (cmd.code == CMD_OV_RESPONSE) &&
    !wp_sync_r && (cmd.wdata[15:8] == 8'h00) &&
    (cmd.wdata[RESP_MODE_MSB:RESP_MODE_LSB] == MODE_DISABLE_RETRY);

  // strap defaults land one edge after reset release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      captured_r <= 1'b0;
      fault_thr_r <= '0;
      warn_thr_r <= '0;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      fault_thr_r <= scale_strap(setpoint_address_strap, FAULT_SCALE);
      warn_thr_r <= scale_strap(setpoint_address_strap, WARN_SCALE);
    end else begin
      if (wr_fault_ok) begin
        fault_thr_r <= cmd.wdata;
      end
      if (wr_warn_ok) begin
        warn_thr_r <= cmd.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_r <= RESP_RESET;
    end else if (wr_resp_ok) begin
      resp_r <= cmd.wdata[7:0];
    end
  end

  // command answers, one cycle after each request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= cmd.valid;
      rsp_r.ok <= 1'b0;
      rsp_r.rdata <= '0;
      if (cmd.valid && cmd.write) begin
        rsp_r.ok <= wr_fault_ok || wr_warn_ok || wr_resp_ok || clear_req;
      end else if (cmd.valid) begin
        if (cmd.code == CMD_OV_FAULT_THR) begin
          rsp_r.ok <= 1'b1;
          rsp_r.rdata <= fault_thr_r;
        end else if (cmd.code == CMD_OV_WARN_THR) begin
          rsp_r.ok <= 1'b1;
          rsp_r.rdata <= warn_thr_r;
        end else if (cmd.code == CMD_OV_RESPONSE) begin
          rsp_r.ok <= 1'b1;
          rsp_r.rdata <= {8'h00, resp_r};
        end else if (cmd.code == CMD_STATUS_VOUT) begin
          rsp_r.ok <= 1'b1;
          rsp_r.rdata <= {8'h00, SV_ZERO | (8'(fault_r) << SV_OV_FAULT_BIT)
            | (8'(warn_r) << SV_OV_WARN_BIT)};
        end
      end
    end
  end

  // a new event in the clearing cycle keeps its flag
  always_comb begin
    fault_nxt = fault_now || (fault_r && !clear_req);
    warn_nxt = warn_now || (warn_r && !clear_req);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_r <= 1'b0;
      warn_r <= 1'b0;
      sum_r <= 1'b0;
      alert_oe_n_r <= 1'b1;
    end else begin
      fault_r <= fault_nxt;
      warn_r <= warn_nxt;
      sum_r <= fault_nxt || warn_nxt;
      alert_oe_n_r <= !(fault_nxt || warn_nxt);
    end
  end

  always_comb begin
    state_nxt = state_r;
    timer_start = 1'b0;
    case (state_r)
      ST_INIT: begin
        state_nxt = output_on_request ? ST_RUN : ST_OFF;
      end
      ST_RUN: begin
        if (other_fault_shutdown) begin
          state_nxt = ST_LATCH;
        end else if (fault_now) begin
          if (retry_field == RETRY_NONE) begin
            state_nxt = ST_LATCH;
          end else begin
            state_nxt = ST_WAIT;
            timer_start = 1'b1;
          end
        end else if (!output_on_request) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        if (other_fault_shutdown) begin
          state_nxt = ST_LATCH;
        end else if (output_on_request) begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (other_fault_shutdown) begin
          state_nxt = ST_LATCH;
        end else if (!output_on_request) begin
          state_nxt = ST_OFF;
        end else if (timer_done && below_warn) begin
          state_nxt = ST_RUN;
        end
      end
      ST_LATCH: begin
        state_nxt = ST_LATCH;
      end
      default: begin
        state_nxt = ST_LATCH;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_INIT;
      power_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      power_en_r <= (state_nxt == ST_RUN);
    end
  end

  retry_timer #(
    .UNIT_CYCLES(RETRY_UNIT_CYCLES),
    .CNT_W(TIMER_W)
  ) u_retry_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(timer_start),
    .delay_sel(resp_r[RESP_DELAY_MSB:RESP_DELAY_LSB]),
    .done(timer_done)
  );

  assign rsp = rsp_r;
  assign host_alert_output = 1'b0;
  assign host_alert_oe_n = alert_oe_n_r;
  assign alert_line_low = alert_low_r;
  assign power_stage_enable = power_en_r;
  assign status_word_vout = sum_r;
  assign status_vout_ov_fault = fault_r;
  assign status_vout_ov_warn = warn_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_latch_trip;
    state_r == ST_RUN && fault_now && !other_fault_shutdown &&
      retry_field == RETRY_NONE;
  endsequence

  sequence s_held_off;
    !power_en_r [*8];
  endsequence

  sequence s_restart_ready;
    state_r == ST_WAIT && timer_done && below_warn &&
      output_on_request && !other_fault_shutdown;
  endsequence

  AST_FAULT_SETS_STATUS: assert property (
    fault_now |=> status_vout_ov_fault && status_word_vout &&
      !host_alert_oe_n)
    else $error("fault exceedance not reported");

  AST_WARN_SETS_STATUS: assert property (
    warn_now |=> status_vout_ov_warn && status_word_vout)
    else $error("warning exceedance not reported");

  AST_FAULT_STICKY: assert property (
    status_vout_ov_fault && !clear_req |=>
      status_vout_ov_fault && !host_alert_oe_n)
    else $error("fault flag dropped without clear");

  AST_EQUAL_NOT_EXCEED: assert property (
    captured_r && vout_meas == fault_thr_r && !fault_r |=> !fault_r)
    else $error("equal value counted as fault");

  AST_LATCH_OFF: assert property (
    s_latch_trip |=> s_held_off)
    else $error("output not latched off");

  AST_RESTART_BELOW_WARN: assert property (
    $rose(power_en_r) && $past(state_r) == ST_WAIT |->
      $past(vout_meas) < $past(warn_thr_r))
    else $error("restart above warning threshold");

  AST_RETRY_RESTARTS: assert property (
    s_restart_ready |=> power_en_r && state_r == ST_RUN)
    else $error("retry did not restart");

  AST_RANGE_REJECT: assert property (
    wr_req && cmd.code == CMD_OV_FAULT_THR && cmd.wdata > FAULT_THR_MAX
      && captured_r |=> $stable(fault_thr_r) && !rsp.ok)
    else $error("out-of-range threshold accepted");

  AST_WP_BLOCKS: assert property (
    wr_req && wp_sync_r && captured_r |=> $stable(fault_thr_r) &&
      $stable(warn_thr_r) && $stable(resp_r))
    else $error("write accepted under protection");

  AST_MODE_FIXED: assert property (
    resp_r[RESP_MODE_MSB:RESP_MODE_LSB] == MODE_DISABLE_RETRY)
    else $error("response mode not disable-and-retry");

  AST_STRAP_DEFAULT: assert property (
    $rose(captured_r) |->
      fault_thr_r == scale_strap($past(setpoint_address_strap),
        FAULT_SCALE) && resp_r == RESP_RESET)
    else $error("fault threshold default wrong");
endmodule : vout_overvoltage_fault_manager

`default_nettype wire

// ==== dv/alert_host_model.sv ====
`default_nettype none

module alert_host_model (
  input wire logic alert_oe_n,
  input wire logic alert_data,
  output logic alert_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // the host side holds a pull-up, so the wire is high unless the device
  // enables its open-drain driver with a low data bit
  assign alert_wire = (!alert_oe_n && !alert_data) ? 1'b0 : 1'b1;
endmodule : alert_host_model

`default_nettype wire

// ==== dv/test_vout_overvoltage_fault_manager.sv ====
`default_nettype none

module test_vout_overvoltage_fault_manager;
  timeunit 1ns;
  timeprecision 1ps;
  import ov_pkg::*;
  localparam int UNIT = 20;
  logic clk, reset_n, wp, on_req, oth_flt, wire_lvl;
  cmd_req_t cmd;
  cmd_rsp_t rsp;
  logic [15:0] vout, strap, q;
  logic alert_d, alert_oe_n, line_low, pwr, sw_vout, sv_flt, sv_warn, ok;
  int num_errors = 0;
  int total_checks = 0;
  int n;
  int dl[3] = '{0, 3, 7};

  vout_overvoltage_fault_manager #(
    .RETRY_UNIT_CYCLES(UNIT), .TIMER_W(24)) dut (
    .clk(clk), .reset_n(reset_n), .cmd(cmd), .rsp(rsp), .vout_meas(vout),
    .setpoint_address_strap(strap), .write_protect_pin(wp),
    .output_on_request(on_req), .other_fault_shutdown(oth_flt),
    .host_alert_in(wire_lvl), .host_alert_output(alert_d),
    .host_alert_oe_n(alert_oe_n), .alert_line_low(line_low),
    .power_stage_enable(pwr), .status_word_vout(sw_vout),
    .status_vout_ov_fault(sv_flt), .status_vout_ov_warn(sv_warn));

  alert_host_model host (.alert_oe_n(alert_oe_n), .alert_data(alert_d),
    .alert_wire(wire_lvl));

  function automatic logic [15:0] b16(input logic x);
    return {15'h0, x};
  endfunction : b16

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one request per call; an idle cycle follows so valid never toggles twice
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] d);
    cmd = '{1'b1, wr, code, d};
    @(negedge clk);
    cmd.valid = 1'b0;
    ok = rsp.ok;
    q = rsp.rdata;
    chk("rsp valid", b16(rsp.valid), 16'h0001);
    @(negedge clk);
  endtask : xfer

  task automatic wrt(input logic [7:0] code, input logic [15:0] d,
                     input logic exp_ok);
    xfer(1'b1, code, d);
    chk("write ok", b16(ok), b16(exp_ok));
  endtask : wrt

  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    xfer(1'b0, code, 16'h0000);
    chk("read data", q, exp);
  endtask : rd

  task automatic restart();
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : restart

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // the whole sequence needs about 750 cycles
  initial begin
    #20000;
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    cmd = '0;
    vout = 16'h1000;
    strap = 16'h1000;
    wp = 1'b0;
    on_req = 1'b1;
    oth_flt = 1'b0;
    restart();
    rd(CMD_OV_FAULT_THR, 16'h1198);
    rd(CMD_OV_WARN_THR, 16'h1148);
    rd(CMD_OV_RESPONSE, 16'h0080);
    $display("defaults test done");
    wrt(CMD_OV_FAULT_THR, 16'hC000, 1'b1);
    wrt(CMD_OV_FAULT_THR, 16'hC001, 1'b0);
    rd(CMD_OV_FAULT_THR, 16'hC000);
    wrt(CMD_OV_WARN_THR, 16'hC001, 1'b0);
    wrt(CMD_OV_RESPONSE, 16'h0040, 1'b0);
    wrt(CMD_OV_RESPONSE, 16'h0180, 1'b0);
    wp = 1'b1;
    repeat (3) @(negedge clk);
    wrt(CMD_OV_FAULT_THR, 16'h1198, 1'b0);
    wrt(CMD_OV_RESPONSE, 16'h0089, 1'b0);
    wrt(CMD_OV_WARN_THR, 16'h1000, 1'b0);
    rd(CMD_OV_FAULT_THR, 16'hC000);
    rd(CMD_OV_RESPONSE, 16'h0080);
    rd(CMD_OV_WARN_THR, 16'h1148);
    $display("write test done");
    vout = 16'h1148;
    repeat (3) @(negedge clk);
    chk("warn at limit", b16(sv_warn), 16'h0000);
    vout = 16'h1149;
    @(negedge clk);
    chk("warn flag", b16(sv_warn), 16'h0001);
    chk("summary", b16(sw_vout), 16'h0001);
    chk("fault flag", b16(sv_flt), 16'h0000);
    vout = 16'h1000;
    repeat (4) @(negedge clk);
    chk("alert wire", b16(wire_lvl), 16'h0000);
    chk("alert data", b16(alert_d), 16'h0000);
    chk("alert seen", b16(line_low), 16'h0001);
    chk("warn sticky", b16(sv_warn), 16'h0001);
    rd(CMD_STATUS_VOUT, 16'h0040);
    wrt(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    chk("warn cleared", b16(sv_warn), 16'h0000);
    chk("alert off", b16(alert_oe_n), 16'h0001);
    wp = 1'b0;
    repeat (3) @(negedge clk);
    wrt(CMD_OV_FAULT_THR, 16'h1198, 1'b1);
    wrt(CMD_OV_WARN_THR, 16'h1148, 1'b1);
    $display("warning test done");
    vout = 16'h1199;
    @(negedge clk);
    vout = 16'h1000;
    chk("fault flag", b16(sv_flt), 16'h0001);
    chk("summary", b16(sw_vout), 16'h0001);
    chk("alert drive", b16(alert_oe_n), 16'h0000);
    repeat (200) @(negedge clk);
    chk("latched off", b16(pwr), 16'h0000);
    xfer(1'b0, CMD_STATUS_VOUT, 16'h0000);
    chk("fault in status", q & 16'h0080, 16'h0080);
    restart();
    chk("on after reset", b16(pwr), 16'h0001);
    chk("flag after reset", b16(sv_flt), 16'h0000);
    $display("latch test done");
    for (int i = 0; i < 3; i++) begin
      wrt(CMD_OV_RESPONSE, {10'h2, 3'(dl[i]) | 3'h1, 3'(dl[i])}, 1'b1);
      vout = 16'h1199;
      @(negedge clk);
      vout = 16'h1000;
      @(negedge clk);
      chk("disabled", b16(pwr), 16'h0000);
      n = 2;
      while (pwr !== 1'b1 && n < 400) begin
        @(negedge clk);
        n++;
      end
      chk("retry delay", b16(n inside {[(dl[i] + 1) * UNIT - 1 :
        (dl[i] + 1) * UNIT + 3]}), 16'h0001);
      chk("fault kept", b16(sv_flt), 16'h0001);
      wrt(CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    end
    wrt(CMD_OV_RESPONSE, 16'h0088, 1'b1);
    vout = 16'h1199;
    @(negedge clk);
    vout = 16'h1149;
    repeat (3 * UNIT) @(negedge clk);
    chk("held above warn", b16(pwr), 16'h0000);
    vout = 16'h1000;
    repeat (4) @(negedge clk);
    chk("restart below warn", b16(pwr), 16'h0001);
    vout = 16'h1199;
    @(negedge clk);
    vout = 16'h1000;
    on_req = 1'b0;
    repeat (3 * UNIT) @(negedge clk);
    chk("commanded off", b16(pwr), 16'h0000);
    on_req = 1'b1;
    restart();
    wrt(CMD_OV_RESPONSE, 16'h0088, 1'b1);
    vout = 16'h1199;
    @(negedge clk);
    vout = 16'h1000;
    oth_flt = 1'b1;
    @(negedge clk);
    oth_flt = 1'b0;
    repeat (3 * UNIT) @(negedge clk);
    chk("other fault off", b16(pwr), 16'h0000);
    $display("retry test done");
    report_and_stop();
  end
endmodule : test_vout_overvoltage_fault_manager

`default_nettype wire
